// File: logic/eeprom_pkg.sv
// shared constants and types for the two-wire eeprom write front end
package eeprom_pkg;
    localparam int CLK_MHZ = 100;
    // program window length; plain default, to be set per process
    localparam int PROG_TIME_US = 1000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int PAGE_BYTES = 32;
    localparam int FIFO_DEPTH = 32;
    localparam logic [3:0] TYPE_ARRAY = 4'ha;
    localparam logic [3:0] TYPE_AUX = 4'hb;
    localparam logic [1:0] FN_IDPAGE = 2'h0;
    localparam logic [1:0] FN_UID = 2'h1;
    localparam logic [1:0] FN_LOCK = 2'h2;
    localparam logic [1:0] FN_SWP = 2'h3;
    localparam int LOCK_DATA_BIT = 1;
    localparam int SWP_DATA_BIT = 0;
    localparam logic SWP_RESET = 1'b0;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic [3:0] ACK_BIT = 4'h8;

    typedef enum logic [2:0] {TGT_NONE, TGT_ARRAY, TGT_IDPAGE, TGT_LOCK, TGT_SWP} target_t;
    typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_WADR_HI, ST_WADR_LO, ST_DATA, ST_PROG} phase_t;

    // one byte handed to the memory array during the program cycle
    typedef struct packed {
        target_t tgt;
        logic [11:0] addr;
        logic [7:0] data;
    } wr_word_t;

    // pins sampled from outside the clock domain
    typedef struct packed {
        logic wp;
        logic [2:0] strap;
        logic sda;
        logic scl;
    } pins_t;
endpackage

// File: logic/eeprom_front.sv
// two-wire eeprom addressing and write front end with its drain fifo
// Function
// - address byte: 4-bit type, three select bits, direction bit, msb first.
// - type 1010 selects the main array.
// - type 1011 selects auxiliary space: id page, lock, soft protect, unique id.
// - respond only when select bits equal the three strapped select inputs.
// - last address bit one means read, zero means write.
// - ack address on match, nack on mismatch, then back to standby.
// - two word address bytes follow, high first, each acknowledged.
// - array location is word address bits 11:0, bits 15:12 ignored.
// - aux function from bits 10:9: 00 id page, 10 lock, 11 swp, 01 uid.
// - protect pin or soft protect bit set: nack data except soft protect bytes, keep locations.
// - protect pin low and soft protect clear: ack array and soft protect bytes, id page and lock bytes until locked; nack unique id.
// - stop in the tenth clock after data starts programming, else not.
// - during programming ignore the bus and give no response.
// - internal address counter advances by one per written byte.
// - page write continues without stop, up to 32 data bytes.
// - only a stop after the last ack slot programs; else discard.
// - page write increments only the five low address bits.
// - over thirty-two bytes wrap in the page and overwrite earlier ones.
// - sample on rising bus clock, change outputs on falling edge.
// - ack holds data low through the whole ninth clock.
// - floating protect pin counts as low; the code has no pull-down and uses the sampled pin level as it is.
`timescale 1ns/1ns

module page_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    // depth must be a power of two; pointers carry one wrap bit
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fifo_t;
    fifo_t q;
    fifo_t d;
    logic full;
    logic empty;

    assign full = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
    assign empty = (q.wp == q.rp);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = q.mem[q.rp[AW-1:0]];

    // push and pop may happen in the same cycle
    always_comb begin
        d = q;
        if (in_valid_i && !full) begin
            d.mem[q.wp[AW-1:0]] = in_data_i;
            d.wp = q.wp + 1'b1;
        end
        if (out_ready_i && !empty) begin
            d.rp = q.rp + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

module eeprom_front
    import eeprom_pkg::*;
#(
    parameter int prog_cycles_p = PROG_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic select_strap_hi_i,
    input wire logic select_strap_mid_i,
    input wire logic select_strap_lo_i,
    input wire logic protect_pin_i,
    output logic mem_valid_o,
    output wr_word_t mem_word_o,
    input wire logic mem_ready_i,
    output logic busy_o,
    output logic soft_protect_bit_o,
    output logic id_lock_o,
    output logic [11:0] cur_addr_o
);
    typedef struct packed {
        pins_t s1;
        pins_t s2;
        logic scl_p;
        logic sda_p;
        phase_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic ack;
        logic oe;
        logic aux;
        target_t tgt;
        logic [3:0] wadr_hi;
        logic [6:0] page;
        logic [4:0] page_byte_offset;
        logic [11:0] addr;
        logic [1:0] nok;
        logic pend;
        logic [PAGE_BYTES-1:0][7:0] pbuf;
        logic [PAGE_BYTES-1:0] mask;
        logic [5:0] idx;
        logic [19:0] timer;
        logic soft_protect_bit;
        logic lock;
        logic busy;
        logic o_valid;
        wr_word_t o_word;
    } fe_t;

    fe_t q;
    fe_t d;
    pins_t raw;
    logic rise, fall, start, stop, wr_prot, byte_done, acc, push;
    logic f_ready, f_valid, f_take;
    logic [7:0] nb;
    logic [11:0] wadr;
    wr_word_t f_in, f_out;

    // per-byte acceptance from the protection state at that moment
    function automatic logic accept(target_t t, logic prot, logic lock);
        unique case (t)
            TGT_ARRAY: accept = !prot;
            TGT_IDPAGE: accept = !prot && !lock;
            TGT_LOCK: accept = !prot && !lock;
            TGT_SWP: accept = 1'b1;
            default: accept = 1'b0;
        endcase
    endfunction

    assign raw = '{wp: protect_pin_i,
                   strap: {select_strap_hi_i, select_strap_mid_i, select_strap_lo_i},
                   sda: sda_i, scl: scl_i};
    // bus events use the second sync stage and its delayed copy only
    assign rise = q.s2.scl && !q.scl_p;
    assign fall = !q.s2.scl && q.scl_p;
    assign start = q.s2.scl && q.scl_p && q.sda_p && !q.s2.sda;
    assign stop = q.s2.scl && q.scl_p && !q.sda_p && q.s2.sda;
    // sync flops reset low but resample the pin every cycle, so an undriven protect pin is not held low
    assign wr_prot = q.s2.wp || q.soft_protect_bit;
    assign byte_done = rise && (q.st != ST_IDLE) && (q.st != ST_PROG) && (q.cnt == 4'h7);
    assign nb = {q.sh[6:0], q.s2.sda};
    assign wadr = {q.wadr_hi, nb};
    assign acc = accept(q.tgt, wr_prot, q.lock);

    // drain the latched page into the fifo while programming
    assign push = (q.st == ST_PROG) && !q.idx[5] && q.mask[q.idx[4:0]];
    assign f_in = '{tgt: q.tgt,
                    addr: {(q.tgt == TGT_ARRAY) ? q.page : 7'h0, q.idx[4:0]},
                    data: q.pbuf[q.idx[4:0]]};
    assign f_take = !q.o_valid || mem_ready_i;

    page_fifo #(.W($bits(wr_word_t)), .D(FIFO_DEPTH)) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(push),
        .in_data_i(f_in),
        .in_ready_o(f_ready),
        .out_valid_o(f_valid),
        .out_data_o(f_out),
        .out_ready_i(f_take)
    );

    always_comb begin
        d = q;
        d.s1 = raw;
        d.s2 = q.s1;
        d.scl_p = q.s2.scl;
        d.sda_p = q.s2.sda;
        // output stage; a stalled memory backs up the fifo and the drain
        if (f_valid && f_take) begin
            d.o_valid = 1'b1;
            d.o_word = f_out;
        end else if (mem_ready_i) begin
            d.o_valid = 1'b0;
        end
        if (q.st == ST_PROG) begin
            // bus is deaf here; polling address bytes get no ack
            d.oe = 1'b0;
            if (!q.idx[5] && (!q.mask[q.idx[4:0]] || f_ready)) begin
                d.idx = q.idx + 6'h01;
            end
            if (q.timer != 20'h0_0000) begin
                d.timer = q.timer - 20'h0_0001;
            end else if (q.idx[5]) begin
                d.st = ST_IDLE;
                d.mask = '0;
            end
        end else begin
            // ack driven from the fall after bit 8 to the fall after clock 9
            if (fall && q.cnt == ACK_BIT) begin
                d.oe = q.ack;
            end else if (fall && q.cnt == 4'h0) begin
                d.oe = 1'b0;
            end
            if (rise && q.cnt == ACK_BIT) begin
                d.cnt = 4'h0;
            end else if (rise && q.st != ST_IDLE) begin
                d.sh = nb;
                d.cnt = q.cnt + 4'h1;
            end
            if (byte_done) begin
                d.ack = 1'b0;
                unique case (q.st)
                    ST_DEV: begin
                        d.aux = (nb[7:4] == TYPE_AUX);
                        if ((nb[7:4] == TYPE_ARRAY || nb[7:4] == TYPE_AUX)
                            && nb[3:1] == q.s2.strap) begin
                            d.ack = 1'b1;
                            // reads are served elsewhere; write goes on to address
                            d.st = nb[0] ? ST_IDLE : ST_WADR_HI;
                        end else begin
                            d.st = ST_IDLE;
                        end
                    end
                    ST_WADR_HI: begin
                        d.wadr_hi = nb[3:0];
                        d.ack = 1'b1;
                        d.st = ST_WADR_LO;
                    end
                    ST_WADR_LO: begin
                        d.ack = 1'b1;
                        d.st = ST_DATA;
                        d.nok = 2'h0;
                        d.mask = '0;
                        d.page_byte_offset = wadr[4:0];
                        if (!q.aux) begin
                            d.tgt = TGT_ARRAY;
                            d.page = wadr[11:5];
                            d.addr = wadr;
                        end else begin
                            d.page = 7'h00;
                            unique case (q.wadr_hi[2:1])
                                FN_IDPAGE: d.tgt = TGT_IDPAGE;
                                FN_UID: d.tgt = TGT_NONE;
                                FN_LOCK: d.tgt = TGT_LOCK;
                                FN_SWP: d.tgt = TGT_SWP;
                            endcase
                        end
                    end
                    ST_DATA: begin
                        d.ack = acc;
                        if (acc) begin
                            d.nok = q.nok + {1'b0, q.nok != 2'h3};
                            unique case (q.tgt)
                                TGT_ARRAY, TGT_IDPAGE: begin
                                    // later bytes at the same offset overwrite
                                    d.pbuf[q.page_byte_offset] = nb;
                                    d.mask[q.page_byte_offset] = 1'b1;
                                    d.page_byte_offset = q.page_byte_offset + 5'h01;
                                    if (q.tgt == TGT_ARRAY) begin
                                        d.addr = {q.page, q.page_byte_offset + 5'h01};
                                    end
                                end
                                TGT_LOCK: d.pend = nb[LOCK_DATA_BIT];
                                TGT_SWP: d.pend = nb[SWP_DATA_BIT];
                                default: d.pend = q.pend;
                            endcase
                        end
                    end
                    default: d.ack = 1'b0;
                endcase
            end
            if (stop) begin
                d.cnt = 4'h0;
                d.oe = 1'b0;
                // a stop sits in the clock after an ack slot, so one rise has been counted
                if (q.st == ST_DATA && q.cnt == 4'h1 && q.nok != 2'h0
                    && !(q.tgt == TGT_SWP && q.nok != 2'h1)) begin
                    d.st = ST_PROG;
                    d.idx = 6'h00;
                    d.timer = 20'(prog_cycles_p - 1);
                    if (q.tgt == TGT_SWP) begin
                        d.soft_protect_bit = q.pend;
                    end
                    if (q.tgt == TGT_LOCK && q.pend) begin
                        d.lock = 1'b1;
                    end
                end else begin
                    d.st = ST_IDLE;
                    d.mask = '0;
                end
            end
            if (start) begin
                d.st = ST_DEV;
                d.cnt = 4'h0;
                d.oe = 1'b0;
            end
        end
        d.busy = (d.st == ST_PROG); // registered so busy_o leaves a flop
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
            q.soft_protect_bit <= SWP_RESET;
            q.lock <= LOCK_RESET;
        end else begin
            q <= d;
        end
    end

    // open-drain data pin: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = q.oe;
    assign mem_valid_o = q.o_valid;
    assign mem_word_o = q.o_word;
    assign busy_o = q.busy;
    assign soft_protect_bit_o = q.soft_protect_bit;
    assign id_lock_o = q.lock;
    assign cur_addr_o = q.addr;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    a_nack_standby: assert property (byte_done && q.st == ST_DEV
        && nb[3:1] != q.s2.strap |=> q.st == ST_IDLE && !q.ack)
        else $error("mismatched address not refused");
    a_strap_match: assert property ($rose(q.ack) && q.st == ST_WADR_HI
        |-> q.sh[3:1] == q.s2.strap)
        else $error("address acked without strap match");
    a_protect_nack: assert property (byte_done && q.st == ST_DATA
        && q.s2.wp && q.tgt != TGT_SWP |=> !q.ack && $stable(q.mask))
        else $error("protected data byte acked or stored");
    a_open_ack: assert property (byte_done && q.st == ST_DATA && !wr_prot
        && q.tgt == TGT_ARRAY |=> q.ack)
        else $error("unprotected data byte refused");
    a_page_wrap: assert property (byte_done && q.st == ST_DATA && acc
        && q.tgt == TGT_ARRAY |=> q.page_byte_offset == $past(q.page_byte_offset) + 5'h01
        && $stable(q.page))
        else $error("page offset step wrong");
    a_prog_start: assert property (stop && q.st == ST_DATA && q.cnt == 4'h1
        && q.nok == 2'h1 |=> busy_o)
        else $error("valid stop did not start programming");
    a_stop_discard: assert property (stop && q.st == ST_DATA
        && q.cnt != 4'h1 |=> !busy_o && q.mask == '0)
        else $error("misplaced stop not discarded");
    a_refused_none: assert property (stop && q.st == ST_DATA && q.nok == 2'h0
        |=> !busy_o)
        else $error("program cycle after all bytes refused");
    a_prog_quiet: assert property (busy_o ##1 busy_o |-> !sda_oe_o [*2])
        else $error("bus driven during program cycle");
    a_ack_hold: assert property (rise && q.cnt == ACK_BIT && q.ack
        |-> sda_oe_o)
        else $error("ack not held through ninth clock");
endmodule

// File: bench/bus_master.sv
// bus controller model driving the two-wire bus from the far side
`timescale 1ns/1ns

module bus_master (
    input wire logic dev_oe_i,
    input wire logic dev_sda_i,
    output logic scl_o,
    output logic sda_o
);
    logic pull_low;
    logic seen_low;
    // open-drain data line with pull-up: low while either party pulls it
    assign sda_o = !(pull_low || (dev_oe_i && !dev_sda_i));
    // clock stands high between frames
    initial begin
        scl_o = 1'b1;
        pull_low = 1'b0;
    end
    // start: data falls while clock high, also usable as a repeated start
    task automatic start_c();
        pull_low = 1'b0;
        #63 scl_o = 1'b1;
        #62 pull_low = 1'b1;
        #62 scl_o = 1'b0;
    endtask
    // stop: data rises while clock high
    task automatic stop_c();
        pull_low = 1'b1;
        #63 scl_o = 1'b1;
        #62 pull_low = 1'b0;
        #63;
    endtask
    // one bit: data set while the clock is low, then one full clock pulse
    task automatic clock_bit(input logic b);
        #20 pull_low = !b;
        #43 scl_o = 1'b1;
        #62 scl_o = 1'b0;
    endtask
    // eight bits msb first, then release the line for the ninth clock
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i]);
        end
        #20 pull_low = 1'b0;
        #43 scl_o = 1'b1;
        seen_low = !sda_o;
        // ack only counts if the line is low both when the clock rises and again just before it falls
        #61 ack = seen_low && !sda_o;
        #1 scl_o = 1'b0;
    endtask
endmodule

// File: bench/testbench.sv
// self-checking bench for the eeprom write front end
`timescale 1ns/1ns

module testbench;
    import eeprom_pkg::*;
    localparam int prog_p = 200;
    localparam logic [2:0] strap = 3'h5;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic scl, sda, sda_pull, sda_oe, protect, mem_valid, mem_ready, busy, soft_protect_bit, lock;
    wr_word_t mem_word;
    logic [11:0] cur_addr;
    int bad_count = 0;
    int check_count = 0;
    wr_word_t got[$];

    eeprom_front #(.prog_cycles_p(prog_p)) eeprom_front_inst (.ref_clk_i(clk), .rstn_i(rstn),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_pull), .sda_oe_o(sda_oe),
        .select_strap_hi_i(strap[2]), .select_strap_mid_i(strap[1]),
        .select_strap_lo_i(strap[0]), .protect_pin_i(protect), .mem_valid_o(mem_valid),
        .mem_word_o(mem_word), .mem_ready_i(mem_ready), .busy_o(busy),
        .soft_protect_bit_o(soft_protect_bit), .id_lock_o(lock), .cur_addr_o(cur_addr));
    bus_master bus_master_inst (.dev_oe_i(sda_oe), .dev_sda_i(sda_pull), .scl_o(scl),
        .sda_o(sda));

    // 100 MHz clock
    initial begin
        forever #5 clk = !clk;
    end
    // memory side: record every word the array takes
    always @(posedge clk) begin
        if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
            got.push_back(mem_word);
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one write frame: address, two word bytes, n data bytes, stop
    task automatic frame(input logic [7:0] hi, input logic [7:0] lo, input logic [3:0] t,
                         input int n, input logic [7:0] d0, input logic dack);
        logic a;
        bus_master_inst.start_c();
        bus_master_inst.send_byte({t, strap, 1'b0}, a);
        check(a, 1'b1);
        bus_master_inst.send_byte(hi, a);
        check(a, 1'b1);
        bus_master_inst.send_byte(lo, a);
        check(a, 1'b1);
        for (int k = 0; k < n; k++) begin
            bus_master_inst.send_byte(d0 + k[7:0], a);
            check(a, dack);
        end
        bus_master_inst.stop_c();
        // a soft protect write of more than one byte is discarded
        check(busy, dack && !(t == TYPE_AUX && hi[2:1] == FN_SWP && n > 1));
    endtask

    // bounded wait for the program cycle to end
    task automatic wait_done();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check(busy, 1'b0);
    endtask

    task automatic t_byte();
        frame(8'hf1, 8'h23, TYPE_ARRAY, 1, 8'h5a, 1'b1);
        wait_done();
        check(got.size(), 1);
        check(got[0], {TGT_ARRAY, 12'h123, 8'h5a});
        check(cur_addr, 12'h124);
        got.delete();
        $display("test byte write done");
    endtask

    // ack polling: nack while programming, ack once finished
    task automatic t_poll();
        logic a;
        int n;
        frame(8'h00, 8'h40, TYPE_ARRAY, 1, 8'h11, 1'b1);
        bus_master_inst.start_c();
        bus_master_inst.send_byte({TYPE_ARRAY, strap, 1'b0}, a);
        check(a, 1'b0);
        n = 0;
        while (a !== 1'b1 && n < 20) begin
            bus_master_inst.start_c();
            bus_master_inst.send_byte({TYPE_ARRAY, strap, 1'b0}, a);
            n++;
        end
        bus_master_inst.stop_c();
        check(a, 1'b1);
        check(got.size(), 1);
        got.delete();
        $display("test polling done");
    endtask

    // wrong select, wrong type, flipped select bit, read direction; stop too early
    task automatic t_refuse();
        logic a;
        logic [7:0] cs [4];
        logic ex [4];
        cs = '{{TYPE_ARRAY, ~strap, 1'b0}, {4'hc, strap, 1'b0},
               {TYPE_ARRAY, strap ^ 3'h1, 1'b0}, {TYPE_AUX, strap, 1'b1}};
        ex = '{1'b0, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            bus_master_inst.start_c();
            bus_master_inst.send_byte(cs[i], a);
            check(a, ex[i]);
            bus_master_inst.stop_c();
            check(busy, 1'b0);
        end
        bus_master_inst.start_c();
        bus_master_inst.send_byte({TYPE_ARRAY, strap, 1'b0}, a);
        bus_master_inst.send_byte(8'h01, a);
        bus_master_inst.stop_c();
        check(busy, 1'b0);
        // one accepted byte, then a stop one clock late: nothing programs
        bus_master_inst.start_c();
        bus_master_inst.send_byte({TYPE_ARRAY, strap, 1'b0}, a);
        bus_master_inst.send_byte(8'h00, a);
        bus_master_inst.send_byte(8'h20, a);
        bus_master_inst.send_byte(8'h99, a);
        check(a, 1'b1);
        bus_master_inst.clock_bit(1'b0);
        bus_master_inst.stop_c();
        check(busy, 1'b0);
        $display("test refusals done");
    endtask

    // 34 bytes from offset 30 wrap in the page; the array is stalled so the drain backs up in the fifo
    task automatic t_page();
        int k;
        @(negedge clk) mem_ready <= 1'b0;
        frame(8'h05, 8'h5e, TYPE_ARRAY, 34, 8'h80, 1'b1);
        repeat (40) @(negedge clk);
        check({mem_valid, got.size()}, {1'b1, 32'd0});
        mem_ready <= 1'b1;
        wait_done();
        check(got.size(), 32);
        for (int o = 0; o < 32; o++) begin
            k = (o + 2) % 32;
            if (k < 2) k += 32;
            check(got[o], {TGT_ARRAY, 12'h540 | o[11:0], 8'h80 + k[7:0]});
        end
        check(cur_addr, 12'h540);
        got.delete();
        $display("test page write done");
    endtask

    // hardware pin and soft bit protection
    task automatic t_protect();
        @(negedge clk) protect <= 1'b1;
        frame(8'h00, 8'h10, TYPE_ARRAY, 2, 8'h33, 1'b0);
        frame(8'h06, 8'h00, TYPE_AUX, 1, 8'h01, 1'b1);
        wait_done();
        check(soft_protect_bit, 1'b1);
        @(negedge clk) protect <= 1'b0;
        frame(8'h00, 8'h10, TYPE_ARRAY, 1, 8'h33, 1'b0);
        bus_master_inst.start_c();
        frame(8'h06, 8'h00, TYPE_AUX, 2, 8'h00, 1'b1);
        wait_done();
        check(soft_protect_bit, 1'b1);
        frame(8'h06, 8'h00, TYPE_AUX, 1, 8'h00, 1'b1);
        wait_done();
        check({soft_protect_bit, got.size()}, 33'd0);
        $display("test protection done");
    endtask

    // id page write, unique id refusal, lock, then locked page refusal
    task automatic t_idpage();
        frame(8'h00, 8'h03, TYPE_AUX, 1, 8'h77, 1'b1);
        wait_done();
        check({got[0].tgt, got[0].data}, {TGT_IDPAGE, 8'h77});
        frame(8'h02, 8'h00, TYPE_AUX, 1, 8'h55, 1'b0);
        frame(8'h04, 8'h00, TYPE_AUX, 1, 8'h02, 1'b1);
        wait_done();
        check(lock, 1'b1);
        frame(8'h00, 8'h03, TYPE_AUX, 1, 8'h66, 1'b0);
        check(got.size(), 1);
        $display("test id page done");
    endtask

    // watchdog: the whole run needs well under half a millisecond
    initial begin
        #500000;
        bad_count++;
        close_out();
    end

    initial begin
        protect = 1'b0;
        mem_ready = 1'b1;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        check({busy, soft_protect_bit, lock, sda_oe, mem_valid, cur_addr}, 17'd0);
        repeat (8) @(negedge clk);
        t_byte();
        t_poll();
        t_refuse();
        t_page();
        t_protect();
        t_idpage();
        close_out();
    end
endmodule
